// ### hw/pbctl_pkg.sv
// Constants and types shared by the system control block and its button timer
package pbctl_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_REG_OUT = 8'h1d;
    localparam logic [7:0] ADDR_PB_TIMING = 8'h30;
    localparam logic [7:0] ADDR_CTRL_FIRST = 8'h35;
    localparam logic [7:0] ADDR_CTRL_SECOND = 8'h36;
    localparam logic [7:0] RST_REG_OUT = 8'hb0;
    localparam logic [7:0] RST_PB_TIMING = 8'h2a;
    localparam logic [7:0] RST_CTRL_FIRST = 8'h10;
    localparam logic [7:0] RST_CTRL_SECOND = 8'h00;
    // ==========================================================
    // Field positions
    localparam int OUT_EN_BIT = 7;
    localparam int VCODE_LSB = 2;
    localparam int TYPE_BIT = 1;
    localparam int GATE_BIT = 7;
    localparam int WAKE1_BIT = 6;
    localparam int WAKE2_BIT = 5;
    localparam int WARN_LSB = 3;
    localparam int HOLD_LSB = 1;
    localparam int STORE_BIT = 7;
    localparam int RESTART_LSB = 4;
    localparam int MASK_BIT = 2;
    localparam int PWRCYC_BIT = 1;
    localparam int DEFAULT_BIT = 0;
    // ==========================================================
    // Output voltage
    localparam logic [11:0] BASE_MV = 12'd600;
    localparam logic [11:0] STEP_MV = 12'd100;
    // ==========================================================
    // Timing: clock period in ns, durations in milliseconds counted on a 1 ms tick
    localparam int CLK_PERIOD_NS = 50;
    localparam int NS_PER_MS = 1_000_000;
    localparam int MS_CYCLES = NS_PER_MS / CLK_PERIOD_NS;
    localparam logic [13:0] WAKE1_SHORT_MS = 14'd125;
    localparam logic [13:0] WAKE1_LONG_MS = 14'd500;
    localparam logic [13:0] WAKE2_SHORT_MS = 14'd1000;
    localparam logic [13:0] WAKE2_LONG_MS = 14'd2000;
    localparam logic [13:0] WARN_STEP_MS = 14'd500;
    localparam logic [13:0] HOLD_MS [4] = '{14'd4000, 14'd8000, 14'd10000, 14'd14000};
    localparam logic [13:0] RESTART_MS [4] = '{14'd600, 14'd1200, 14'd2400, 14'd5000};
    localparam logic [1:0] DEBOUNCE_TICKS = 2'd2;
    typedef enum logic {PWR_ON, PWR_RESTART} power_state_t;
endpackage

// ### hw/pb_timer_if.sv
// Link between the register logic and the pushbutton timer
`timescale 1ns/100ps
interface pb_timer_if;
    logic button_high;
    logic vin_valid;
    logic gate;
    logic wake1_sel;
    logic wake2_sel;
    logic [1:0] warn_code;
    logic [1:0] hold_code;
    logic ms_tick;
    logic wake1;
    logic wake2;
    logic warn;
    logic power_cycle_request;
    modport ctl (output button_high, vin_valid, gate, wake1_sel, wake2_sel, warn_code, hold_code,
                 input ms_tick, wake1, wake2, warn, power_cycle_request);
    modport tmr (input button_high, vin_valid, gate, wake1_sel, wake2_sel, warn_code, hold_code,
                 output ms_tick, wake1, wake2, warn, power_cycle_request);
endinterface

// ### hw/button_timer.sv
// Pushbutton debounce and press duration timer
`timescale 1ns/100ps
module button_timer #(
    parameter int MS_CYCLES = pbctl_pkg::MS_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    pb_timer_if.tmr pb
);
    typedef struct packed {
        logic [14:0] pre;
        logic tick;
        logic low;
        logic [1:0] bounce;
        logic [13:0] held;
        logic fired;
        logic wake1;
        logic wake2;
        logic warn;
        logic rst;
    } tmr_state_t;

    tmr_state_t s;
    tmr_state_t next_s;
    logic [13:0] w1_ms;
    logic [13:0] w2_ms;
    logic [13:0] hold_ms;
    logic [13:0] warn_ms;

    assign w1_ms = pb.wake1_sel ? pbctl_pkg::WAKE1_LONG_MS : pbctl_pkg::WAKE1_SHORT_MS;
    assign w2_ms = pb.wake2_sel ? pbctl_pkg::WAKE2_LONG_MS : pbctl_pkg::WAKE2_SHORT_MS;
    assign hold_ms = pbctl_pkg::HOLD_MS[pb.hold_code];
    assign warn_ms = hold_ms - (14'(pb.warn_code) + 14'd1) * pbctl_pkg::WARN_STEP_MS;

    always_comb begin
        logic [13:0] held1;
        held1 = s.held + 14'd1;
        next_s = s;
        next_s.wake1 = 1'b0;
        next_s.wake2 = 1'b0;
        next_s.warn = 1'b0;
        next_s.rst = 1'b0;
        next_s.tick = (s.pre == 15'(MS_CYCLES - 1));
        next_s.pre = next_s.tick ? 15'd0 : s.pre + 15'd1;
        if (s.tick) begin
            // Level must differ on consecutive ticks before it is believed
            if (!pb.button_high != s.low) begin
                if (s.bounce == pbctl_pkg::DEBOUNCE_TICKS - 2'd1) begin
                    next_s.low = !pb.button_high;
                    next_s.bounce = 2'd0;
                end else begin
                    next_s.bounce = s.bounce + 2'd1;
                end
            end else begin
                next_s.bounce = 2'd0;
            end
            if (!s.low) begin
                next_s.held = 14'd0;
                next_s.fired = 1'b0;
            end else if (s.held != 14'h3fff) begin
                next_s.held = held1;
                next_s.wake1 = (held1 == w1_ms);
                next_s.wake2 = (held1 == w2_ms);
                next_s.warn = (held1 == warn_ms);
                // A gated reset waits, still held, for valid input until held reaches 16383 ms
                if (held1 >= hold_ms && !s.fired && (!pb.gate || pb.vin_valid)) begin
                    next_s.rst = 1'b1;
                    next_s.fired = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pb.ms_tick = s.tick;
    assign pb.wake1 = s.wake1;
    assign pb.wake2 = s.wake2;
    assign pb.warn = s.warn;
    assign pb.power_cycle_request = s.rst;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_wake1_time: assert property (pb.wake1 |-> s.held == (pb.wake1_sel ? 14'd500 : 14'd125))
        else $error("first wake at wrong time");
    a_wake2_time: assert property (pb.wake2 |-> s.held == (pb.wake2_sel ? 14'd2000 : 14'd1000))
        else $error("second wake at wrong time");
    a_warn_lead: assert property (pb.warn |-> s.held + 14'(pb.warn_code) * 14'd500 + 14'd500 == hold_ms)
        else $error("warning lead wrong");
    a_hold_reached: assert property (pb.power_cycle_request |-> s.held >= hold_ms && !$past(s.fired))
        else $error("button reset before hold time");
    a_gate_input: assert property (pb.power_cycle_request && pb.gate |-> $past(pb.vin_valid))
        else $error("gated reset without valid input");
    a_release_clear: assert property (s.tick && !s.low |=> s.held == 14'd0)
        else $error("held time kept after release");
    c_wake1: cover property (pb.wake1);
    c_button_reset: cover property (pb.power_cycle_request);
endmodule

// ### hw/pushbutton_ldo_system_control.sv
// System control registers for output regulator, pushbutton and device resets
`timescale 1ns/100ps
module pushbutton_ldo_system_control #(
    parameter int MS_CYCLES = pbctl_pkg::MS_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic pushbutton_input_in,
    input wire logic vin_valid_in,
    input wire logic int_request_in,
    output logic output_enable_out,
    output logic [4:0] output_voltage_code_out,
    output logic [11:0] output_voltage_mv_out,
    output logic load_switch_output_out,
    output logic rails_off_out,
    output logic storage_mode_out,
    output logic int_out,
    output logic wake1_out,
    output logic wake2_out,
    output logic reset_warning_out,
    output logic button_reset_out
);
    typedef struct packed {
        logic [7:0] r_out;
        logic [7:0] r_pb;
        logic [7:0] r_c0;
        logic [7:0] r_c1;
        logic [7:0] rdata;
        logic btn1;
        logic btn2;
        logic vin1;
        logic vin2;
        pbctl_pkg::power_state_t pstate;
        logic [13:0] restart_ms;
        logic [1:0] restart_code;
        logic storage;
        logic intr;
        logic [11:0] mv;
    } ctl_state_t;

    localparam ctl_state_t RESET_STATE = '{
        r_out: pbctl_pkg::RST_REG_OUT,
        r_pb: pbctl_pkg::RST_PB_TIMING,
        r_c0: pbctl_pkg::RST_CTRL_FIRST,
        r_c1: pbctl_pkg::RST_CTRL_SECOND,
        rdata: 8'h00,
        btn1: 1'b1,
        btn2: 1'b1,
        vin1: 1'b0,
        vin2: 1'b0,
        pstate: pbctl_pkg::PWR_ON,
        restart_ms: 14'd0,
        restart_code: 2'd0,
        storage: 1'b0,
        intr: 1'b0,
        mv: 12'd1800
    };

    ctl_state_t s;
    ctl_state_t next_s;
    logic wr_out_reg;
    logic wr_c0;
    logic cycle_req;
    logic default_req;

    pb_timer_if pb ();

    button_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pb(pb)
    );

    // ==========================================================
    // Timer configuration
    assign pb.button_high = s.btn2;
    assign pb.vin_valid = s.vin2;
    assign pb.gate = s.r_pb[pbctl_pkg::GATE_BIT];
    assign pb.wake1_sel = s.r_pb[pbctl_pkg::WAKE1_BIT];
    assign pb.wake2_sel = s.r_pb[pbctl_pkg::WAKE2_BIT];
    assign pb.warn_code = s.r_pb[pbctl_pkg::WARN_LSB +: 2];
    assign pb.hold_code = s.r_pb[pbctl_pkg::HOLD_LSB +: 2];

    assign wr_out_reg = reg_wr_in && reg_addr_in == pbctl_pkg::ADDR_REG_OUT;
    assign wr_c0 = reg_wr_in && reg_addr_in == pbctl_pkg::ADDR_CTRL_FIRST;
    assign cycle_req = pb.power_cycle_request || (wr_c0 && reg_wdata_in[pbctl_pkg::PWRCYC_BIT]);
    assign default_req = wr_c0 && reg_wdata_in[pbctl_pkg::DEFAULT_BIT];

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.btn1 = pushbutton_input_in;
        next_s.btn2 = s.btn1;
        next_s.vin1 = vin_valid_in;
        next_s.vin2 = s.vin1;
        if (reg_wr_in) begin
            if (reg_addr_in == pbctl_pkg::ADDR_REG_OUT) begin
                next_s.r_out = reg_wdata_in;
            end else if (reg_addr_in == pbctl_pkg::ADDR_PB_TIMING) begin
                next_s.r_pb = reg_wdata_in;
            end else if (reg_addr_in == pbctl_pkg::ADDR_CTRL_FIRST) begin
                next_s.r_c0 = reg_wdata_in;
                // Request bits act once and never read back as set
                next_s.r_c0[pbctl_pkg::PWRCYC_BIT] = 1'b0;
                next_s.r_c0[pbctl_pkg::DEFAULT_BIT] = 1'b0;
            end else if (reg_addr_in == pbctl_pkg::ADDR_CTRL_SECOND) begin
                next_s.r_c1 = reg_wdata_in;
            end
        end
        if (reg_rd_in) begin
            if (reg_addr_in == pbctl_pkg::ADDR_REG_OUT) begin
                next_s.rdata = s.r_out;
            end else if (reg_addr_in == pbctl_pkg::ADDR_PB_TIMING) begin
                next_s.rdata = s.r_pb;
            end else if (reg_addr_in == pbctl_pkg::ADDR_CTRL_FIRST) begin
                next_s.rdata = s.r_c0;
            end else if (reg_addr_in == pbctl_pkg::ADDR_CTRL_SECOND) begin
                next_s.rdata = s.r_c1;
            end else begin
                next_s.rdata = 8'h00;
            end
        end
        if (cycle_req || default_req) begin
            next_s.r_out = pbctl_pkg::RST_REG_OUT;
            next_s.r_pb = pbctl_pkg::RST_PB_TIMING;
            next_s.r_c0 = pbctl_pkg::RST_CTRL_FIRST;
            next_s.r_c1 = pbctl_pkg::RST_CTRL_SECOND;
        end
        case (s.pstate)
            pbctl_pkg::PWR_ON: begin
                if (cycle_req) begin
                    next_s.pstate = pbctl_pkg::PWR_RESTART;
                    next_s.restart_ms = 14'd0;
                    // Delay is taken from the setting in force before defaults land
                    next_s.restart_code = s.r_c0[pbctl_pkg::RESTART_LSB +: 2];
                end
            end
            pbctl_pkg::PWR_RESTART: begin
                // A fresh request while the rails are down starts the delay over
                if (cycle_req) begin
                    next_s.restart_ms = 14'd0;
                    next_s.restart_code = s.r_c0[pbctl_pkg::RESTART_LSB +: 2];
                end else if (pb.ms_tick) begin
                    if (s.restart_ms + 14'd1 >= pbctl_pkg::RESTART_MS[s.restart_code]) begin
                        next_s.pstate = pbctl_pkg::PWR_ON;
                    end else begin
                        next_s.restart_ms = s.restart_ms + 14'd1;
                    end
                end
            end
            default: begin
                next_s.pstate = pbctl_pkg::PWR_ON;
            end
        endcase
        next_s.storage = s.r_c0[pbctl_pkg::STORE_BIT] && !s.vin2 && s.btn2;
        next_s.intr = (int_request_in || pb.wake1 || pb.wake2 || pb.warn) && !s.r_c0[pbctl_pkg::MASK_BIT];
        next_s.mv = pbctl_pkg::BASE_MV
            + 12'(next_s.r_out[pbctl_pkg::VCODE_LSB +: 5]) * pbctl_pkg::STEP_MV;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata_out = s.rdata;
    assign rails_off_out = (s.pstate == pbctl_pkg::PWR_RESTART);
    assign output_enable_out = s.r_out[pbctl_pkg::OUT_EN_BIT] && !rails_off_out;
    assign output_voltage_code_out = s.r_out[pbctl_pkg::VCODE_LSB +: 5];
    assign output_voltage_mv_out = s.mv;
    assign load_switch_output_out = s.r_out[pbctl_pkg::TYPE_BIT];
    assign storage_mode_out = s.storage;
    assign int_out = s.intr;
    assign wake1_out = pb.wake1;
    assign wake2_out = pb.wake2;
    assign reset_warning_out = pb.warn;
    assign button_reset_out = pb.power_cycle_request;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_enable_off_write: assert property (wr_out_reg && !reg_wdata_in[7] && !cycle_req
        |=> !output_enable_out)
        else $error("output stays on after disable");
    a_enable_on_write: assert property (wr_out_reg && reg_wdata_in[7] && !cycle_req && !rails_off_out
        |=> output_enable_out)
        else $error("output stays off after enable");
    a_voltage_map: assert property (wr_out_reg && !cycle_req
        |=> output_voltage_mv_out == 12'd600 + 12'($past(reg_wdata_in[6:2])) * 12'd100)
        else $error("output target does not follow code");
    a_type_select: assert property (wr_out_reg && !cycle_req
        |=> load_switch_output_out == $past(reg_wdata_in[1]))
        else $error("output type does not follow bit");
    a_storage_cond: assert property (storage_mode_out |-> $past(s.r_c0[7]) && !$past(s.vin2) && $past(s.btn2))
        else $error("storage mode without its conditions");
    a_mask_silence: assert property (s.r_c0[2] |=> !int_out)
        else $error("interrupt shown while masked");
    a_int_follows: assert property (int_request_in && !s.r_c0[2] |=> int_out)
        else $error("unmasked interrupt not shown");
    a_request_clear: assert property (wr_c0 |=> s.r_c0[1:0] == 2'h0)
        else $error("request bit reads back as set");
    a_power_cycle: assert property (cycle_req
        |=> rails_off_out && s.r_pb == 8'h2a && s.r_out == 8'hb0 && s.r_c0 == 8'h10)
        else $error("power cycle did not restore defaults");
    a_default_req: assert property (default_req && !cycle_req && s.pstate == pbctl_pkg::PWR_ON
        |=> !rails_off_out && s.r_out == 8'hb0 && s.r_c1 == 8'h00)
        else $error("default request misbehaved");
    a_restart_bound: assert property (rails_off_out |-> s.restart_ms < pbctl_pkg::RESTART_MS[s.restart_code])
        else $error("restart delay overrun");
    c_storage: cover property (storage_mode_out);
    c_restart_done: cover property (rails_off_out ##1 !rails_off_out);
    c_int_seen: cover property (int_out);
endmodule

// ### test/pbctl_host_model.sv
// Host and pushbutton stand-in for the system control block
`timescale 1ns/100ps
module pbctl_host_model (
    input wire logic clk_in,
    input wire logic [7:0] reg_rdata_in,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic pushbutton_out,
    output logic vin_valid_out,
    output logic int_request_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        pushbutton_out = 1'b1;
        vin_valid_out = 1'b1;
        int_request_out = 1'b0;
    end
    // ==========================================================
    // Register strobe port
    // Idle address and data flip so a stale value never looks valid
    task automatic idle_bus();
        reg_addr_out <= ~reg_addr_out;
        reg_wdata_out <= ~reg_wdata_out;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clk_in);
        reg_wr_out <= 1'b0;
        idle_bus();
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clk_in);
        reg_rd_out <= 1'b0;
        idle_bus();
        @(posedge clk_in);
        #1;
        d = reg_rdata_in;
    endtask
    // ==========================================================
    // Button pin, supply detect and interrupt source
    task automatic pins(input logic pb, input logic vin);
        @(posedge clk_in);
        pushbutton_out <= pb;
        vin_valid_out <= vin;
    endtask
    task automatic pulse_irq();
        @(posedge clk_in);
        int_request_out <= 1'b1;
        @(posedge clk_in);
        int_request_out <= 1'b0;
    endtask
endmodule

// ### test/pushbutton_ldo_system_control_tb_top.sv
// Self-checking bench for the system control block
`timescale 1ns/100ps
module pushbutton_ldo_system_control_tb_top;
    // Short tick keeps multi-second holds within the run budget
    localparam int MS = 2;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, pb, vin, irq;
    logic en_out, ls_out, rails_out, store_out, int_o, w1, w2, warn_o, brst;
    logic [4:0] code_out;
    logic [11:0] mv_out;
    logic [4:0] ev;
    logic [31:0] seed = 32'd38;
    logic [31:0] r;
    logic [7:0] adr [4] = '{pbctl_pkg::ADDR_REG_OUT, pbctl_pkg::ADDR_PB_TIMING,
                            pbctl_pkg::ADDR_CTRL_FIRST, pbctl_pkg::ADDR_CTRL_SECOND};
    int mdl [4];
    int evc [5] = '{default: 0};
    int evt [5] = '{default: 0};
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    int c, tp, ts;

    always #25 clk_in = ~clk_in;

    pbctl_host_model host (.clk_in(clk_in), .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
        .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .pushbutton_out(pb),
        .vin_valid_out(vin), .int_request_out(irq));

    pushbutton_ldo_system_control #(.MS_CYCLES(MS)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .pushbutton_input_in(pb), .vin_valid_in(vin), .int_request_in(irq),
        .output_enable_out(en_out), .output_voltage_code_out(code_out), .output_voltage_mv_out(mv_out),
        .load_switch_output_out(ls_out), .rails_off_out(rails_out), .storage_mode_out(store_out),
        .int_out(int_o), .wake1_out(w1), .wake2_out(w2), .reset_warning_out(warn_o),
        .button_reset_out(brst));

    // ==========================================================
    // Event log: count and last cycle of each one-cycle pulse
    assign ev = {int_o, brst, warn_o, w2, w1};
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        foreach (evc[i]) begin
            if (ev[i] === 1'b1) begin
                evc[i] <= evc[i] + 1;
                evt[i] <= cyc;
            end
        end
    end

    // ==========================================================
    // Model, checks and helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic defaults();
        mdl[0] = int'(pbctl_pkg::RST_REG_OUT);
        mdl[1] = int'(pbctl_pkg::RST_PB_TIMING);
        mdl[2] = int'(pbctl_pkg::RST_CTRL_FIRST);
        mdl[3] = int'(pbctl_pkg::RST_CTRL_SECOND);
    endtask
    task automatic chk_count(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        chk_count({24'h000000, got}, {24'h000000, exp});
    endtask
    task automatic wr(input int i, input logic [7:0] v);
        host.write_reg(adr[i], v);
        mdl[i] = (i == 2) ? int'(v & 8'hfc) : int'(v);
    endtask
    task automatic check_regs(input logic off);
        int v;
        for (int i = 0; i < 4; i++) begin
            host.read_reg(adr[i], d);
            chk_byte(d, 8'(mdl[i]));
        end
        v = (mdl[0] >> 2) & 31;
        chk_count({13'h0, en_out, code_out, mv_out, ls_out},
                  {13'h0, 1'(mdl[0] >> 7) & ~off, 5'(v), 12'(600 + v * 100), 1'(mdl[0] >> 1)});
    endtask
    task automatic wait_ev(input int i, input int lim);
        int c0;
        c0 = evc[i];
        for (int k = 0; k < lim && evc[i] == c0; k++) begin
            @(posedge clk_in);
            #1;
        end
    endtask
    task automatic press_check(input int w1ms, input int w2ms, input int wnms);
        chk_count(32'(evt[0] - tp >= w1ms * MS && evt[0] - tp <= (w1ms + 5) * MS), 32'd1);
        chk_count(32'(evt[1] - evt[0]), 32'(w2ms * MS));
        chk_count(32'(evt[2] - evt[0]), 32'(wnms * MS));
    endtask
    task automatic rails_span(input int ms);
        for (int k = 0; k < 30000 && rails_out === 1'b1; k++) begin
            @(posedge clk_in);
            #1;
        end
        chk_count(32'(cyc - ts >= (ms - 2) * MS && cyc - ts <= (ms + 2) * MS), 32'd1);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog, well above the roughly 42k cycles the tests need
    initial begin
        repeat (90000) @(posedge clk_in);
        fails++;
        print_verdict();
    end

    // ==========================================================
    // Tests
    initial begin
        defaults();
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        check_regs(1'b0);
        host.read_reg(8'h31, d);
        chk_byte(d, 8'h00);
        $display("test reset_values done");
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            wr(k % 4, (k % 4 == 2) ? (r[7:0] & 8'h7c) : r[7:0]);
            check_regs(1'b0);
        end
        host.write_reg(8'h00, r[15:8]);
        check_regs(1'b0);
        $display("test register_access done");
        host.write_reg(adr[2], 8'h01);
        defaults();
        check_regs(1'b0);
        $display("test register_default done");
        wr(2, 8'h04);
        c = evc[4];
        host.pulse_irq();
        repeat (4) @(posedge clk_in);
        chk_count(32'(evc[4] - c), 32'd0);
        wr(2, 8'h00);
        host.pulse_irq();
        repeat (4) @(posedge clk_in);
        chk_count(32'(evc[4] - c), 32'd1);
        $display("test interrupt_mask done");
        wr(2, 8'h80);
        host.pins(1'b1, 1'b0);
        repeat (8) @(posedge clk_in);
        chk_count({31'h0, store_out}, 32'd1);
        host.pins(1'b1, 1'b1);
        repeat (8) @(posedge clk_in);
        chk_count({31'h0, store_out}, 32'd0);
        wr(2, 8'h00);
        host.pins(1'b1, 1'b0);
        repeat (8) @(posedge clk_in);
        chk_count({31'h0, store_out}, 32'd0);
        $display("test storage_mode done");
        // Shortest hold and restart, ungated, supply absent
        wr(1, 8'h00);
        c = evc[4];
        host.pins(1'b0, 1'b0);
        tp = cyc;
        wait_ev(3, 4100 * MS);
        press_check(125, 875, 3375);
        chk_count(32'(evt[3] - evt[0]), 32'(3875 * MS));
        chk_count(32'(evc[4] - c), 32'd3);
        repeat (2) @(posedge clk_in);
        #1;
        ts = cyc;
        chk_count({30'h0, rails_out, en_out}, 32'd2);
        host.pins(1'b1, 1'b0);
        defaults();
        check_regs(1'b1);
        rails_span(600);
        $display("test button_reset done");
        // Gated reset waits for a valid supply, 8 s hold, longest restart
        wr(2, 8'h30);
        wr(1, 8'hda);
        host.pins(1'b0, 1'b0);
        tp = cyc;
        wait_ev(2, 6100 * MS);
        press_check(500, 500, 5500);
        c = evc[3];
        wait_ev(3, 2500 * MS);
        chk_count(32'(evc[3] - c), 32'd0);
        host.pins(1'b0, 1'b1);
        wait_ev(3, 20 * MS);
        chk_count(32'(evc[3] - c), 32'd1);
        host.pins(1'b1, 1'b1);
        ts = cyc;
        defaults();
        rails_span(5000);
        $display("test gated_reset done");
        // Early release restarts the press timer
        c = evc[0];
        host.pins(1'b0, 1'b1);
        repeat (100 * MS) @(posedge clk_in);
        host.pins(1'b1, 1'b1);
        repeat (20 * MS) @(posedge clk_in);
        chk_count(32'(evc[0] - c), 32'd0);
        host.pins(1'b0, 1'b1);
        tp = cyc;
        wait_ev(0, 200 * MS);
        chk_count(32'(evt[0] - tp >= 125 * MS && evt[0] - tp <= 130 * MS), 32'd1);
        host.pins(1'b1, 1'b1);
        repeat (20 * MS) @(posedge clk_in);
        $display("test press_release done");
        // Delay comes from the setting in force before the request
        wr(2, 8'h20);
        host.write_reg(adr[2], 8'h02);
        repeat (2) @(posedge clk_in);
        #1;
        ts = cyc;
        chk_count({30'h0, rails_out, en_out}, 32'd2);
        defaults();
        check_regs(1'b1);
        rails_span(2400);
        $display("test power_cycle done");
        print_verdict();
    end
endmodule
